/* File: src/rsic_regs.vh */
// Purpose: constants for the reset, sleep and interrupt control unit
// Assumes: 200 MHz ref_clk, 32-bit classic wishbone register bus
// Notes: offsets are byte addresses of aligned words
`ifndef RSIC_REGS_VH
`define RSIC_REGS_VH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define RSIC_CLK_KHZ 200000
`define RSIC_OST_MS 18
`define RSIC_WDT_MS 18
`define RSIC_OST_CYCLES (`RSIC_OST_MS * `RSIC_CLK_KHZ)
`define RSIC_WDT_CYCLES (`RSIC_WDT_MS * `RSIC_CLK_KHZ)

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define RSIC_OFF_STATUS 8'h00
`define RSIC_OFF_BANK 8'h04
`define RSIC_OFF_INT_STATUS 8'h08
`define RSIC_OFF_INT_MASK 8'h0C
`define RSIC_OFF_WDT_CTRL 8'h10
`define RSIC_OFF_TIMER_CFG 8'h14
`define RSIC_OFF_IO_DIR5 8'h18
`define RSIC_OFF_IO_DIR6 8'h1C
`define RSIC_OFF_IO_DIR7 8'h20
`define RSIC_OFF_STATE 8'h24
`define RSIC_OFF_PC 8'h28

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define RSIC_ST_TIMEOUT 4
`define RSIC_ST_PWRDOWN 3
`define RSIC_ST_POR_LO 5
`define RSIC_ST_POR_HI 6
`define RSIC_WC_WAKE_DIS 0
`define RSIC_WC_ROPT 3
`define RSIC_WC_OSC_RUN 4
`define RSIC_WC_WDT_EN 5
`define RSIC_WC_OPEN_DRAIN 6
`define RSIC_TC_GIE 6
`define RSIC_TC_PAB 3
`define RSIC_IRQ_TICK 0
`define RSIC_IRQ_EXT 3

// ----------------------------------------------------------------
// reset values and masks
// ----------------------------------------------------------------
`define RSIC_RST_TIMER_CFG 8'hBF
`define RSIC_RST_WDT_CTRL_SET 8'h31
`define RSIC_RST_WDT_CTRL_CLR 8'h48
`define RSIC_WDT_CTRL_USED 8'h79
`define RSIC_IRQ_USED 8'h09
`define RSIC_RST_IO_DIR 8'hFF
`define RSIC_PC_ALL_ONES 12'hFFF
`define RSIC_VEC_HW 12'h001
`define RSIC_VEC_SW 12'h002

// ----------------------------------------------------------------
// opcodes handled here
// ----------------------------------------------------------------
`define RSIC_OP_SLEEP 13'h0003
`define RSIC_OP_WDT_CLR 13'h0004
`define RSIC_OP_IRQ_ON 13'h0010
`define RSIC_OP_IRQ_OFF 13'h0011
`define RSIC_OP_IRQ_RET 13'h0013
`define RSIC_OP_SOFT_TRAP 13'h1E02

// ----------------------------------------------------------------
// states
// ----------------------------------------------------------------
`define RSIC_S_HOLD 3'h0
`define RSIC_S_RUN 3'h1
`define RSIC_S_HALT 3'h2
`define RSIC_S_STOP 3'h3
`define RSIC_S_WAKE 3'h4

`endif

/* File: src/rsic_ctrl.v */
// Purpose: reset, sleep and interrupt control unit of an 8-bit core
// Assumes: all inputs synchronous to ref_clk; core executes one opcode per instr_valid
// Notes: reset_n is the power-on reset; rst_pin_n is the external reset pin
//
// Functional notes
// [RL1] reset from power-on, pin low, watchdog timeout
// [RL2] hold reset one start-up period after cause
// [RL3] program counter loads all ones on reset
// [RL4] power-on only clears status and bank bits
// [RL5] all port pins become inputs on reset
// [RL6] clear watchdog and prescaler; enable from option
// [RL7] timer config all ones except global enable
// [RL8] set reset values of watchdog control, interrupts
// [RL9] sleep opcode stops oscillator, clears watchdog
// [RL10] halt wakes only by timeout or pin reset
// [RL11] clearing oscillator run bit enters stop mode
// [RL12] pin wake from stop resumes without reset
// [RL13] software prepares wake pins before stop
// [RL14] pin wake re-enables watchdog when option set
// [RL15] timeout or pin reset in stop resets
// [RL16] tick and external requests flagged, mask gated
// [RL17] enabled hardware interrupt vectors to 001
// [RL18] opcodes set and clear global enable
// [RL19] flags set regardless of masks
// [RL20] status read returns flags and mask
// [RL21] return opcode pops stack, sets global enable
// [RL22] soft trap pushes return, vectors to 002; code takes the trap only while global enable is set
// [RL23] service routine clears flag before return
// [RL24] falling external pin and overflow set flags
// [RL25] wake edge sets run bit, restart waits
// [RL26] wake pins enabled when disable bit low
// [RL27] hardware interrupt pushes and clears global enable
`timescale 1ns/1ps
`include "rsic_regs.vh"

module rsic_ctrl #(
	parameter OST_CYCLES = `RSIC_OST_CYCLES,
	parameter WDT_CYCLES = `RSIC_WDT_CYCLES
) (
	// clock and power-on reset
	input wire ref_clk,
	input wire reset_n,
	// wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	// pins and options
	input wire rst_pin_n,
	input wire ext_irq_pin,
	input wire [9:0] wake_pins,
	input wire wdt_option_bit,
	input wire tick_overflow,
	// core instruction side
	input wire instr_valid,
	input wire [12:0] instr_code,
	input wire [11:0] next_pc,
	input wire [11:0] stack_top,
	// core control
	output reg core_reset,
	output reg core_stall,
	output reg osc_enable,
	output reg pc_load,
	output reg [11:0] program_counter,
	output reg stack_push,
	output reg [11:0] push_addr,
	output reg stack_pop,
	output reg prescaler_clear,
	// port control
	output reg [23:0] port_dir,
	output reg open_drain_en,
	output reg ropt_en,
	output reg pull_up_en_n,
	output reg wdt_enable
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function hit;
		input [7:0] adr;
		input [7:0] off;
		begin
			hit = (adr[7:2] == off[7:2]);
		end
	endfunction

	// ----------------------------------------------------------------
	// state and storage
	// ----------------------------------------------------------------
	reg [2:0] state_q;
	reg [2:0] state_d;
	reg [31:0] hold_cnt_q;
	reg por_q;
	reg [7:0] status_reg;
	reg [7:0] bank_select_reg;
	reg [7:0] int_status_reg;
	reg [7:0] int_mask_reg;
	reg [7:0] wdt_ctrl_reg;
	reg [7:0] timer_config_reg;
	reg [31:0] wdt_cnt_q;
	reg [7:0] wdt_pre_q;
	reg ext_prev_q;
	reg [9:0] wake_prev_q;
	reg osc_run_prev_q;

	wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire bus_wr = bus_req & wb_we_i & wb_sel_i[0];
	wire [7:0] wd = wb_dat_i[7:0];
	wire running = (state_q == `RSIC_S_RUN);

	// ----------------------------------------------------------------
	// watchdog
	// ----------------------------------------------------------------
	wire wdt_on = wdt_option_bit & wdt_ctrl_reg[`RSIC_WC_WDT_EN];
	wire [7:0] wdt_ratio_m1 = timer_config_reg[`RSIC_TC_PAB] ?
		((8'h01 << timer_config_reg[2:0]) - 8'h01) : 8'h00;
	wire wdt_base_tick = (wdt_cnt_q == WDT_CYCLES - 1);
	wire wdt_timeout = wdt_on & (state_q != `RSIC_S_HOLD) & wdt_base_tick & (wdt_pre_q == wdt_ratio_m1); // RL1
	wire op_sleep = running & instr_valid & (instr_code == `RSIC_OP_SLEEP);
	wire op_wdt_clr = running & instr_valid & (instr_code == `RSIC_OP_WDT_CLR);

	// ----------------------------------------------------------------
	// wake and interrupt events
	// ----------------------------------------------------------------
	// falling edge on any enabled wake pin; pins assumed pulled high when idle
	wire wake_edge = ~wdt_ctrl_reg[`RSIC_WC_WAKE_DIS] & (|(wake_prev_q & ~wake_pins)); // RL26
	wire ext_fall = ext_prev_q & ~ext_irq_pin; // RL24
	wire reset_event = ~rst_pin_n | wdt_timeout; // RL1 RL10 RL15
	wire osc_run_fall = osc_run_prev_q & ~wdt_ctrl_reg[`RSIC_WC_OSC_RUN];
	wire gie = timer_config_reg[`RSIC_TC_GIE];
	wire [7:0] irq_seen = int_status_reg & int_mask_reg;
	wire irq_take = running & gie & (|irq_seen) & ~osc_run_fall; // RL17
	wire op_irq_on = running & ~irq_take & instr_valid & (instr_code == `RSIC_OP_IRQ_ON);
	wire op_irq_off = running & ~irq_take & instr_valid & (instr_code == `RSIC_OP_IRQ_OFF);
	wire op_irq_ret = running & ~irq_take & instr_valid & (instr_code == `RSIC_OP_IRQ_RET);
	wire op_trap = running & ~irq_take & gie & instr_valid & (instr_code == `RSIC_OP_SOFT_TRAP);
	wire hold_done = (hold_cnt_q >= OST_CYCLES - 1);
	wire wake_done = (state_q == `RSIC_S_WAKE) & hold_done;

	// ----------------------------------------------------------------
	// sequencing
	// ----------------------------------------------------------------
	always @* begin
		state_d = state_q;
		case (state_q)
			`RSIC_S_HOLD: begin
				if (hold_done) begin
					state_d = `RSIC_S_RUN; // RL2
				end
			end
			`RSIC_S_RUN: begin
				if (op_sleep) begin
					state_d = `RSIC_S_HALT; // RL9
				end else if (osc_run_fall) begin
					state_d = `RSIC_S_STOP; // RL11
				end
			end
			`RSIC_S_HALT: begin
				state_d = `RSIC_S_HALT;
			end
			`RSIC_S_STOP: begin
				if (wake_edge) begin
					state_d = `RSIC_S_WAKE; // RL12
				end
			end
			`RSIC_S_WAKE: begin
				if (hold_done) begin
					state_d = `RSIC_S_RUN; // RL25
				end
			end
			default: begin
				state_d = `RSIC_S_HOLD;
			end
		endcase
		if (reset_event) begin
			state_d = `RSIC_S_HOLD; // RL10 RL15
		end
	end

	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= `RSIC_S_HOLD;
			hold_cnt_q <= 32'h00000000;
			por_q <= 1'b1;
		end else begin
			state_q <= state_d;
			// counter restarts on every cause, so a held pin stretches the hold
			if (reset_event || (state_d != state_q)) begin
				hold_cnt_q <= 32'h00000000; // RL2
			end else if (((state_q == `RSIC_S_HOLD) || (state_q == `RSIC_S_WAKE)) && !hold_done) begin
				hold_cnt_q <= hold_cnt_q + 32'h00000001;
			end
			if (state_q == `RSIC_S_HOLD && hold_done) begin
				por_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// watchdog counter and shared prescaler
	// ----------------------------------------------------------------
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			wdt_cnt_q <= 32'h00000000;
			wdt_pre_q <= 8'h00;
		end else if (reset_event || state_q == `RSIC_S_HOLD || op_sleep || op_wdt_clr || !wdt_on) begin
			wdt_cnt_q <= 32'h00000000; // RL6 RL9
			wdt_pre_q <= 8'h00;
		end else if (wdt_base_tick) begin
			// keeps counting in both sleep modes
			wdt_cnt_q <= 32'h00000000;
			wdt_pre_q <= (wdt_pre_q == wdt_ratio_m1) ? 8'h00 : wdt_pre_q + 8'h01;
		end else begin
			wdt_cnt_q <= wdt_cnt_q + 32'h00000001;
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			status_reg <= 8'h18;
			bank_select_reg <= 8'h00;
			int_status_reg <= 8'h00;
			int_mask_reg <= 8'h00;
			wdt_ctrl_reg <= `RSIC_RST_WDT_CTRL_SET;
			timer_config_reg <= `RSIC_RST_TIMER_CFG;
			port_dir <= {3{`RSIC_RST_IO_DIR}};
			ext_prev_q <= 1'b1;
			wake_prev_q <= 10'h3FF;
			osc_run_prev_q <= 1'b1;
		end else begin
			ext_prev_q <= ext_irq_pin;
			wake_prev_q <= wake_pins;
			osc_run_prev_q <= wdt_ctrl_reg[`RSIC_WC_OSC_RUN];
			if (reset_event) begin
				timer_config_reg <= `RSIC_RST_TIMER_CFG; // RL7
				wdt_ctrl_reg <= (wdt_ctrl_reg & ~`RSIC_RST_WDT_CTRL_CLR) | `RSIC_RST_WDT_CTRL_SET; // RL8
				int_status_reg <= 8'h00; // RL8
				int_mask_reg <= 8'h00;
				port_dir <= {3{`RSIC_RST_IO_DIR}}; // RL5
				if (wdt_timeout) begin
					status_reg[`RSIC_ST_TIMEOUT] <= 1'b0; // RL10
				end
				if (por_q) begin
					status_reg[`RSIC_ST_POR_HI:`RSIC_ST_POR_LO] <= 2'b00; // RL4
					bank_select_reg[7:6] <= 2'b00;
				end
			end else begin
				if (bus_wr) begin
					if (hit(wb_adr_i, `RSIC_OFF_STATUS)) begin
						status_reg <= {wd[7:5], status_reg[4:3], wd[2:0]};
					end
					if (hit(wb_adr_i, `RSIC_OFF_BANK)) begin
						bank_select_reg <= wd;
					end
					if (hit(wb_adr_i, `RSIC_OFF_INT_MASK)) begin
						int_mask_reg <= wd & `RSIC_IRQ_USED;
					end
					if (hit(wb_adr_i, `RSIC_OFF_WDT_CTRL)) begin
						wdt_ctrl_reg <= wd & `RSIC_WDT_CTRL_USED; // RL11
					end
					if (hit(wb_adr_i, `RSIC_OFF_TIMER_CFG)) begin
						timer_config_reg <= {wd[7], timer_config_reg[`RSIC_TC_GIE], wd[5:0]};
					end
					if (hit(wb_adr_i, `RSIC_OFF_IO_DIR5)) begin
						port_dir[7:0] <= wd;
					end
					if (hit(wb_adr_i, `RSIC_OFF_IO_DIR6)) begin
						port_dir[15:8] <= wd;
					end
					if (hit(wb_adr_i, `RSIC_OFF_IO_DIR7)) begin
						port_dir[23:16] <= wd;
					end
				end
				// software can only clear flags; a same-cycle event still lands
				int_status_reg <= ((bus_wr && hit(wb_adr_i, `RSIC_OFF_INT_STATUS)) ?
					(int_status_reg & wd) : int_status_reg)
					| {4'h0, ext_fall, 2'b00, tick_overflow}; // RL16 RL19 RL24
				if (wake_edge) begin
					wdt_ctrl_reg[`RSIC_WC_OSC_RUN] <= 1'b1; // RL25
				end
				if (wake_done && wdt_option_bit) begin
					wdt_ctrl_reg[`RSIC_WC_WDT_EN] <= 1'b1; // RL14
				end
				if (op_sleep) begin
					status_reg[`RSIC_ST_TIMEOUT] <= 1'b1;
					status_reg[`RSIC_ST_PWRDOWN] <= 1'b0; // RL10
				end
				if (op_wdt_clr) begin
					status_reg[`RSIC_ST_TIMEOUT] <= 1'b1;
					status_reg[`RSIC_ST_PWRDOWN] <= 1'b1;
				end
				if (op_irq_on || op_irq_ret) begin
					timer_config_reg[`RSIC_TC_GIE] <= 1'b1; // RL18 RL21
				end
				if (op_irq_off || irq_take || op_trap) begin
					timer_config_reg[`RSIC_TC_GIE] <= 1'b0; // RL18 RL27
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// program counter and stack strobes
	// ----------------------------------------------------------------
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			program_counter <= `RSIC_PC_ALL_ONES;
			pc_load <= 1'b0;
			stack_push <= 1'b0;
			stack_pop <= 1'b0;
			push_addr <= 12'h000;
		end else begin
			pc_load <= 1'b0;
			stack_push <= 1'b0;
			stack_pop <= 1'b0;
			if (reset_event) begin
				program_counter <= `RSIC_PC_ALL_ONES; // RL3
			end else if (state_q == `RSIC_S_HOLD && hold_done) begin
				program_counter <= `RSIC_PC_ALL_ONES; // RL3
				pc_load <= 1'b1;
			end else if (irq_take) begin
				program_counter <= `RSIC_VEC_HW; // RL17
				pc_load <= 1'b1;
				stack_push <= 1'b1; // RL27
				push_addr <= next_pc;
			end else if (op_trap) begin
				program_counter <= `RSIC_VEC_SW; // RL22
				pc_load <= 1'b1;
				stack_push <= 1'b1;
				push_addr <= next_pc;
			end else if (op_irq_ret) begin
				program_counter <= stack_top; // RL21
				pc_load <= 1'b1;
				stack_pop <= 1'b1;
			end else if (instr_valid && running) begin
				program_counter <= next_pc;
			end
		end
	end

	// ----------------------------------------------------------------
	// core and port control outputs
	// ----------------------------------------------------------------
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			core_reset <= 1'b1;
			core_stall <= 1'b1;
			osc_enable <= 1'b1;
			prescaler_clear <= 1'b1;
			wdt_enable <= 1'b0;
			open_drain_en <= 1'b0;
			ropt_en <= 1'b0;
			pull_up_en_n <= 1'b1;
		end else begin
			core_reset <= (state_d == `RSIC_S_HOLD); // RL2
			core_stall <= (state_d != `RSIC_S_RUN);
			// oscillator runs during hold; stops in both sleep modes
			osc_enable <= (state_d != `RSIC_S_HALT) && (state_d != `RSIC_S_STOP); // RL9 RL11
			prescaler_clear <= reset_event | op_sleep | op_wdt_clr; // RL6
			wdt_enable <= wdt_on; // RL6
			open_drain_en <= wdt_ctrl_reg[`RSIC_WC_OPEN_DRAIN];
			ropt_en <= wdt_ctrl_reg[`RSIC_WC_ROPT];
			pull_up_en_n <= timer_config_reg[7];
		end
	end

	// ----------------------------------------------------------------
	// wishbone read and ack
	// ----------------------------------------------------------------
	reg [7:0] rd;

	always @* begin
		rd = 8'h00;
		if (hit(wb_adr_i, `RSIC_OFF_STATUS)) begin
			rd = status_reg;
		end else if (hit(wb_adr_i, `RSIC_OFF_BANK)) begin
			rd = bank_select_reg;
		end else if (hit(wb_adr_i, `RSIC_OFF_INT_STATUS)) begin
			rd = irq_seen; // RL20
		end else if (hit(wb_adr_i, `RSIC_OFF_INT_MASK)) begin
			rd = int_mask_reg;
		end else if (hit(wb_adr_i, `RSIC_OFF_WDT_CTRL)) begin
			rd = wdt_ctrl_reg;
		end else if (hit(wb_adr_i, `RSIC_OFF_TIMER_CFG)) begin
			rd = timer_config_reg;
		end else if (hit(wb_adr_i, `RSIC_OFF_IO_DIR5)) begin
			rd = port_dir[7:0];
		end else if (hit(wb_adr_i, `RSIC_OFF_IO_DIR6)) begin
			rd = port_dir[15:8];
		end else if (hit(wb_adr_i, `RSIC_OFF_IO_DIR7)) begin
			rd = port_dir[23:16];
		end else if (hit(wb_adr_i, `RSIC_OFF_STATE)) begin
			rd = {3'b000, wdt_on, por_q, state_q};
		end
	end

	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			// one wait state; unmapped words read zero and still ack
			wb_ack_o <= bus_req;
			if (bus_req && !wb_we_i) begin
				if (hit(wb_adr_i, `RSIC_OFF_PC)) begin
					wb_dat_o <= {20'h00000, program_counter};
				end else begin
					wb_dat_o <= {24'h000000, rd};
				end
			end
		end
	end

endmodule // rsic_ctrl

/* File: sim/rsic_ctrl_assertions.sv */
// Purpose: port-level checks of the reset, sleep and interrupt control unit
// Assumes: one clock domain, power-on reset is reset_n
// Notes: bound into every rsic_ctrl instance
`timescale 1ns/1ps
`include "rsic_regs.vh"
module rsic_chk #(
	parameter OST_CYCLES = 20
) (
	// clock and resets
	input wire ref_clk,
	input wire reset_n,
	input wire rst_pin_n,
	// instruction side
	input wire instr_valid,
	input wire [12:0] instr_code,
	input wire [11:0] stack_top,
	// core control
	input wire core_reset,
	input wire core_stall,
	input wire osc_enable,
	input wire pc_load,
	input wire [11:0] program_counter,
	input wire stack_push,
	input wire stack_pop,
	// port control
	input wire [23:0] port_dir,
	input wire open_drain_en,
	input wire ropt_en,
	input wire pull_up_en_n
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	// ----------------------------------------------------------------
	// hold length
	// ----------------------------------------------------------------
	// restarts on every pin cycle so a long pin pulse never counts
	reg [31:0] hold_q;
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			hold_q <= 32'h0;
		end else if (!rst_pin_n || !core_reset) begin
			hold_q <= 32'h0;
		end else begin
			hold_q <= hold_q + 32'h1;
		end
	end
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	property p_hold; $fell(core_reset) |-> hold_q >= OST_CYCLES - 1; endproperty
	a_hold: assert property (p_hold) else $error("reset hold too short");
	// pc_load with the all-ones address and core_reset release come out on the same edge
	property p_release; $fell(core_reset) |-> pc_load && program_counter == 12'hFFF; endproperty
	a_release: assert property (p_release) else $error("reset release wrong");
	property p_pin; !rst_pin_n |=> core_reset && core_stall && program_counter == 12'hFFF; endproperty
	a_pin: assert property (p_pin) else $error("pin reset not taken");
	property p_dir; !rst_pin_n |=> port_dir == 24'hFFFFFF; endproperty
	a_dir: assert property (p_dir) else $error("ports not inputs");
	// these outputs copy the registers one edge after the reset values land
	property p_cfg; !rst_pin_n |-> ##2 (!open_drain_en && !ropt_en && pull_up_en_n); endproperty
	a_cfg: assert property (p_cfg) else $error("config bits wrong after reset");
	property p_sleep;
		instr_valid && instr_code == `RSIC_OP_SLEEP && !core_stall && rst_pin_n |=>
			(!osc_enable && core_stall) || stack_push;
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep not entered");
	property p_osc; !osc_enable |-> core_stall; endproperty
	a_osc: assert property (p_osc) else $error("running with oscillator off");
	property p_vec; stack_push |-> pc_load && (program_counter == 12'h001 || program_counter == 12'h002); endproperty
	a_vec: assert property (p_vec) else $error("bad vector");
	property p_ret; stack_pop |-> pc_load && program_counter == $past(stack_top); endproperty
	a_ret: assert property (p_ret) else $error("return address wrong");
endmodule // rsic_chk

bind rsic_ctrl rsic_chk #(.OST_CYCLES(OST_CYCLES)) u_chk (.ref_clk(ref_clk), .reset_n(reset_n),
	.rst_pin_n(rst_pin_n), .instr_valid(instr_valid), .instr_code(instr_code), .stack_top(stack_top),
	.core_reset(core_reset), .core_stall(core_stall), .osc_enable(osc_enable), .pc_load(pc_load),
	.program_counter(program_counter), .stack_push(stack_push), .stack_pop(stack_pop), .port_dir(port_dir),
	.open_drain_en(open_drain_en), .ropt_en(ropt_en), .pull_up_en_n(pull_up_en_n));

/* File: sim/rsic_pin_model.sv */
// Purpose: reset pin, interrupt pin, wake pins and tick source around the unit
// Assumes: driven from the bench by task calls
// Notes: pins idle high as with pull-ups enabled
`timescale 1ns/1ps
module rsic_pin_model (
	// clock
	input wire ref_clk,
	// pins toward the unit
	output reg rst_pin_n,
	output reg ext_irq_pin,
	output reg [9:0] wake_pins,
	output reg tick_overflow
);
	initial begin
		rst_pin_n = 1'b1;
		ext_irq_pin = 1'b1;
		wake_pins = 10'h3FF;
		tick_overflow = 1'b0;
	end
	task pin_reset(input integer n);
		begin
			@(posedge ref_clk);
			rst_pin_n <= 1'b0;
			repeat (n) @(posedge ref_clk);
			rst_pin_n <= 1'b1;
		end
	endtask
	task tick;
		begin
			@(posedge ref_clk);
			tick_overflow <= 1'b1;
			@(posedge ref_clk);
			tick_overflow <= 1'b0;
		end
	endtask
	task ext_fall;
		begin
			@(posedge ref_clk);
			ext_irq_pin <= 1'b0;
			repeat (2) @(posedge ref_clk);
			ext_irq_pin <= 1'b1;
		end
	endtask
	task wake(input [3:0] k);
		begin
			@(posedge ref_clk);
			wake_pins[k] <= 1'b0;
			repeat (2) @(posedge ref_clk);
			wake_pins[k] <= 1'b1;
		end
	endtask
endmodule // rsic_pin_model

/* File: sim/tb_reset_sleep_interrupt_ctrl.sv */
// Purpose: self-checking bench of the reset, sleep and interrupt control unit
// Assumes: start-up count 20, watchdog count 30
// Notes: random pc values, register data and wake pin from a fixed seed
`timescale 1ns/1ps
`include "rsic_regs.vh"
module tb_reset_sleep_interrupt_ctrl;
	reg ref_clk, reset_n, cyc, stb, we, wdt_opt, iv;
	reg [7:0] adr;
	reg [31:0] wdat, rd;
	reg [12:0] code;
	reg [11:0] npc, stop;
	reg [3:0] wi, sel;
	wire ack, rst_pin_n, ext_irq_pin, tick, core_reset, core_stall, osc_enable, pc_load, stack_push, stack_pop;
	wire wdt_enable, pclr;
	wire [31:0] wb_dat_o;
	wire [9:0] wake_pins;
	wire [11:0] pc, push_addr;
	wire [23:0] port_dir;
	integer err_total, tests_run, seed, tick_n, loads, i, l0;

	rsic_pin_model u_pins (.ref_clk(ref_clk), .rst_pin_n(rst_pin_n), .ext_irq_pin(ext_irq_pin),
		.wake_pins(wake_pins), .tick_overflow(tick));
	rsic_ctrl #(.OST_CYCLES(20), .WDT_CYCLES(30)) u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
		.wb_ack_o(ack), .rst_pin_n(rst_pin_n), .ext_irq_pin(ext_irq_pin), .wake_pins(wake_pins),
		.wdt_option_bit(wdt_opt), .tick_overflow(tick), .instr_valid(iv), .instr_code(code), .next_pc(npc),
		.stack_top(stop), .core_reset(core_reset), .core_stall(core_stall), .osc_enable(osc_enable),
		.pc_load(pc_load), .program_counter(pc), .stack_push(stack_push), .push_addr(push_addr),
		.stack_pop(stack_pop), .prescaler_clear(pclr), .port_dir(port_dir), .open_drain_en(), .ropt_en(),
		.pull_up_en_n(), .wdt_enable(wdt_enable));

	task end_sim;
		begin
			if (err_total == 0 && tests_run > 0) begin
				$display("Testbench passed");
			end else begin
				$display("Testbench failed");
			end
			$finish;
		end
	endtask
	task chk(input [31:0] seen, input [31:0] exp, input [63:0] what);
		begin
			tests_run = tests_run + 1;
			if (seen !== exp) begin
				err_total = err_total + 1;
				$display("[FAIL] %0s expected %h seen %h", what, exp, seen);
			end
		end
	endtask
	task wb(input w, input [7:0] a, input [7:0] d);
		integer n;
		begin
			@(posedge ref_clk);
			cyc <= 1'b1;
			stb <= 1'b1;
			we <= w;
			adr <= a;
			wdat <= {24'h000000, d};
			n = 0;
			do begin
				@(posedge ref_clk);
				n = n + 1;
			end while (ack !== 1'b1 && n < 50);
			rd = wb_dat_o;
			cyc <= 1'b0;
			stb <= 1'b0;
			chk(ack, 1'b1, "ack");
		end
	endtask
	task op(input [12:0] c);
		begin
			@(posedge ref_clk);
			iv <= 1'b1;
			code <= c;
			@(posedge ref_clk);
			iv <= 1'b0;
			#1;
		end
	endtask
	// k: 0 fetch load, 1 running again, 2 reset entered
	task wsig(input [1:0] k, input integer lim);
		integer n;
		reg hit;
		begin
			n = 0;
			do begin
				@(posedge ref_clk);
				#1;
				n = n + 1;
				hit = k == 0 ? pc_load === 1'b1 : k == 1 ? core_stall === 1'b0 : core_reset === 1'b1;
			end while (!hit && n < lim);
			chk(hit, 1'b1, "wait");
		end
	endtask
	task quiet(input integer n);
		begin
			l0 = loads;
			repeat (n) @(posedge ref_clk);
			chk(loads - l0, 0, "no load");
		end
	endtask
	function [7:0] rst_val(input [7:0] a);
		case (a)
			`RSIC_OFF_WDT_CTRL: rst_val = 8'h31;
			`RSIC_OFF_TIMER_CFG: rst_val = 8'hBF;
			`RSIC_OFF_IO_DIR5: rst_val = 8'hFF;
			default: rst_val = 8'h00;
		endcase
	endfunction
	// w=1 scrambles the five registers, w=0 reads them against reset values
	task tbl(input w);
		reg [7:0] a;
		reg [7:0] d;
		begin
			for (i = 0; i < 5; i = i + 1) begin
				a = 8'h08 + 8'h04 * i[7:0];
				d = 8'($random(seed)) | (a == `RSIC_OFF_WDT_CTRL ? 8'h10 : 8'h00);
				wb(w, a, d);
				if (!w) chk(rd, rst_val(a), "rst reg");
			end
		end
	endtask
	task por_chk(input [7:0] e);
		begin
			wb(1'b0, `RSIC_OFF_STATUS, 8'h00);
			chk(rd & 32'h60, e & 8'h60, "status");
			wb(1'b0, `RSIC_OFF_BANK, 8'h00);
			chk(rd & 32'hC0, e & 8'hC0, "bank");
		end
	endtask

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		tick_n = tick_n + 1;
		if (pc_load === 1'b1) loads = loads + 1;
		if (tick_n == 20000) begin
			err_total = err_total + 1;
			end_sim;
		end
	end
	initial begin
		{reset_n, cyc, stb, we, wdt_opt, iv} = 6'h00;
		adr = 8'h00;
		sel = 4'h1;
		wdat = 32'h0;
		code = 13'h0000;
		seed = 24984;
		npc = 12'($random(seed));
		stop = 12'($random(seed));
		wi = 4'($unsigned($random(seed)) % 10);
		{err_total, tests_run, tick_n, loads} = 128'h0;
		repeat (8) @(posedge ref_clk);
		chk(port_dir, 24'hFFFFFF, "dir");
		chk({core_reset, pc}, 13'h1FFF, "pc");
		reset_n <= 1'b1;
		wsig(0, 40);
		chk(pc, 12'hFFF, "pc");
		tbl(1'b0);
		chk(wdt_enable, 1'b0, "wdt on");
		// a write without the low byte lane must leave the register alone
		sel <= 4'h0;
		wb(1'b1, `RSIC_OFF_BANK, 8'hC0);
		sel <= 4'h1;
		wb(1'b0, `RSIC_OFF_BANK, 8'h00);
		chk(rd, 32'h0, "sel0");
		wb(1'b1, `RSIC_OFF_STATUS, 8'h60);
		wb(1'b1, `RSIC_OFF_BANK, 8'hC0);
		tbl(1'b1);
		u_pins.pin_reset(3);
		wsig(0, 40);
		tbl(1'b0);
		por_chk(8'hE0);
		@(posedge ref_clk);
		reset_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		reset_n <= 1'b1;
		wsig(0, 40);
		por_chk(8'h00);
		u_pins.tick;
		wb(1'b0, `RSIC_OFF_INT_STATUS, 8'h00);
		chk(rd, 32'h0, "isr");
		wb(1'b1, `RSIC_OFF_INT_MASK, 8'h09);
		wb(1'b0, `RSIC_OFF_INT_STATUS, 8'h00);
		chk(rd, 32'h1, "isr");
		u_pins.ext_fall;
		wb(1'b0, `RSIC_OFF_INT_STATUS, 8'h00);
		chk(rd, 32'h9, "isr");
		wb(1'b1, `RSIC_OFF_INT_STATUS, 8'h01);
		wb(1'b0, `RSIC_OFF_INT_STATUS, 8'h00);
		chk(rd, 32'h1, "isr");
		op(`RSIC_OP_IRQ_ON);
		wsig(0, 5);
		chk({stack_push, pc, push_addr}, {1'b1, 12'h001, npc}, "vector");
		wb(1'b1, `RSIC_OFF_INT_STATUS, 8'h00);
		op(`RSIC_OP_IRQ_RET);
		chk({pc_load, stack_pop, pc}, {2'b11, stop}, "return");
		op(`RSIC_OP_SOFT_TRAP);
		chk({pc_load, stack_push, pc}, {2'b11, 12'h002}, "trap");
		op(`RSIC_OP_IRQ_ON);
		op(`RSIC_OP_IRQ_OFF);
		u_pins.tick;
		quiet(8);
		wb(1'b1, `RSIC_OFF_WDT_CTRL, 8'h10);
		op(`RSIC_OP_SLEEP);
		chk({osc_enable, core_stall, pclr}, 3'b011, "sleep");
		wb(1'b0, `RSIC_OFF_STATUS, 8'h00);
		chk(rd[4:3], 2'b10, "t p");
		u_pins.tick;
		u_pins.wake(wi);
		quiet(20);
		chk(core_stall, 1'b1, "stall");
		u_pins.pin_reset(2);
		wsig(0, 40);
		wb(1'b1, `RSIC_OFF_WDT_CTRL, 8'h01);
		repeat (3) @(posedge ref_clk);
		chk(osc_enable, 1'b0, "osc");
		u_pins.wake(wi);
		quiet(30);
		u_pins.pin_reset(2);
		wsig(0, 40);
		wdt_opt <= 1'b1;
		wb(1'b1, `RSIC_OFF_WDT_CTRL, 8'h00);
		l0 = loads;
		u_pins.wake(wi);
		wsig(1, 100);
		chk({loads - l0, core_reset}, 33'h0, "resume");
		wb(1'b0, `RSIC_OFF_WDT_CTRL, 8'h00);
		chk(rd[5:4], 2'b11, "run bit");
		chk(wdt_enable, 1'b1, "wdt on");
		wsig(2, 6000);
		wsig(0, 40);
		chk(wdt_enable, 1'b1, "wdt on");
		wb(1'b0, `RSIC_OFF_STATUS, 8'h00);
		chk(rd[4], 1'b0, "timeout");
		end_sim;
	end
endmodule // tb_reset_sleep_interrupt_ctrl
